// ---- tb/pcsd_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Board side: strap pins, presence pins and downstream clock requests
module pcsd_board_model
  import pcsd_pkg::*;
(
  // Levels chosen by the bench
  input  wire logic [6:0]           strap_cfg,
  input  wire logic [2:1]           pres_cfg_n,
  input  wire logic [NUM_PORTS-1:0] dev_req,
  // Switch side of the shared pins
  input  wire logic [NUM_PORTS-1:0] creq_out,
  input  wire logic [NUM_PORTS-1:0] creq_oe,
  // Pins as the switch sees them
  output logic      [6:0]           strap_pin,
  output logic      [2:1]           pres_pin_n,
  output logic      [NUM_PORTS-1:0] creq_wire
);
  // ----------------------------------------------------------------
  // Strap and presence levels
  // ----------------------------------------------------------------
  // Bits: 0 channel, 1 polarity, 2 payload, 3 refclock, 4 select, 6:5 slot
  always_comb strap_pin = strap_cfg;
  always_comb pres_pin_n = pres_cfg_n;
  // ----------------------------------------------------------------
  // Shared wire with pull-up
  // ----------------------------------------------------------------
  // Downstream device pulls low for its clock; the switch wins when it drives
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      creq_wire[i] = creq_oe[i] ? creq_out[i] : ~dev_req[i];
    end
  end
endmodule : pcsd_board_model

`default_nettype wire

// ---- tb/port_config_strap_decode_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module port_config_strap_decode_tb import pcsd_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst_b;
  logic [6:0]  strap_cfg, strap_pin;         // Strap levels and pins
  logic [2:1]  pres_n, pres_pin_n;           // Presence levels and pins
  logic [2:0]  dev_req, needed, status;      // Stimulus per port
  logic [2:0]  creq_wire, creq_out, creq_oe; // Shared pins
  logic        vc1, vc0x, poldet, refc;      // Decoded single bits
  logic [2:0]  mps, refclk_en, pll_en, l1;   // Payload code, clock state
  logic [2:1]  slot, present;                // Per downstream port
  logic [25:0] obs;                          // All observed outputs
  int          cyc, fails, total_checks;
  integer      seed = 32'haba70e09;
  // Expected result due at a given cycle
  typedef struct packed {int due; logic [25:0] mask; logic [25:0] val;} pcsd_note_type;
  pcsd_note_type notes[$];
  localparam logic [25:0] M_STRAP = 26'h00ff800, M_RST = 26'h3f007ff, M_CLK = 26'h00001ff;
  localparam logic [25:0] M_PRES = 26'h0000600, M_PIN = 26'h3f00000;
  assign obs = {creq_oe, creq_out, vc1, vc0x, poldet, mps, refc, slot, present, refclk_en, pll_en, l1};

  // ----------------------------------------------------------------
  // Design and board
  // ----------------------------------------------------------------
  pcsd_strap_decode dut (.clk(clk), .rst_b(rst_b), .second_channel_enable_strap(strap_pin[0]),
    .rx_polarity_detect_disable_strap(strap_pin[1]), .large_payload_strap(strap_pin[2]),
    .common_refclock_strap(strap_pin[3]), .substate_or_debug_select(strap_pin[4]),
    .slot_connected_strap(strap_pin[6:5]), .slot_presence_n(pres_pin_n), .clock_request_n_in(creq_wire),
    .clock_request_n_out(creq_out), .clock_request_n_oe(creq_oe), .port_clock_needed(needed),
    .per_port_debug_status(status), .vc1_capable(vc1), .vc0_extra_buffers(vc0x),
    .rx_polarity_detect_enable(poldet), .max_payload_code(mps), .common_refclock_cfg(refc),
    .slot_connected(slot), .device_present(present), .refclk_enable(refclk_en), .pll_enable(pll_en),
    .l1_substate_active(l1));
  pcsd_board_model board (.strap_cfg(strap_cfg), .pres_cfg_n(pres_n), .dev_req(dev_req),
    .creq_out(creq_out), .creq_oe(creq_oe), .strap_pin(strap_pin), .pres_pin_n(pres_pin_n),
    .creq_wire(creq_wire));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [25:0] strap_word(input logic [6:0] s);
    return {6'h0, s[0], ~s[0], ~s[1], (s[2] ? MPS_512B : MPS_256B), s[3], s[6:5], 11'h0};
  endfunction : strap_word
  // Clock enables on, substate flags the inverse
  function automatic logic [25:0] clk_word(input logic [2:0] on);
    return {17'h0, on, on, ~on};
  endfunction : clk_word
  task automatic expect_at(input int dly, input logic [25:0] mask, input logic [25:0] val);
    notes.push_back('{cyc + dly, mask, val});
  endtask : expect_at
  // Inputs move 1 ns after the rising edge, apart from the setup at time 0
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Clock, cycle count, monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Outputs are settled at the falling edge; every due note is compared
  always @(negedge clk) begin : monitor
    int i;
    i = 0;
    while (i < notes.size()) begin
      if (notes[i].due == cyc) begin
        check(obs & notes[i].mask, notes[i].val);
        notes.delete(i);
      end else i++;
    end
  end
  initial begin
    #(100 * 3000);
    fails++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset for 5 cycles, then flip the pins to show the capture is held
  task automatic do_reset(input logic [6:0] s);
    rst_b = 1'b0;
    strap_cfg = s;
    needed = 3'h0;
    dev_req = 3'h0;
    expect_at(4, M_RST, clk_word(3'h7));
    step(5);
    rst_b = 1'b1;
    expect_at(1, M_STRAP, strap_word(s));
    step(1);
    strap_cfg = ~s;
    expect_at(6, M_STRAP, strap_word(s));
  endtask : do_reset
  // Request mode: own request, device request, both released together
  task automatic req_scenario;
    step(4);
    expect_at(0, M_CLK | M_PIN, clk_word(3'h0));
    needed = 3'h1;
    expect_at(1, M_PIN, 26'h0800000);
    expect_at(4, M_CLK, clk_word(3'h1));
    step(2);
    dev_req = 3'h4;
    expect_at(3, M_CLK, clk_word(3'h5));
    step(4);
    needed = 3'h0;
    dev_req = 3'h0;
    expect_at(1, M_PIN, 26'h0);
    expect_at(3, M_CLK, clk_word(3'h1));
    expect_at(4, M_CLK, clk_word(3'h0));
    step(5);
  endtask : req_scenario
  // Random pin traffic; debug mode also pins the clocks on
  task automatic rand_loop(input logic sel);
    logic [31:0] r;
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      needed = r[2:0];
      status = r[5:3];
      dev_req = sel ? r[8:6] : 3'h0;
      pres_n = r[10:9];
      expect_at(1, M_PIN, {(sel ? {3'h7, r[5:3]} : {r[2:0], 3'h0}), 20'h0});
      expect_at(3, M_PRES, {15'h0, ~r[10:9], 9'h0});
      if (sel) expect_at(1, M_CLK, clk_word(3'h7));
      step(1);
    end
    step(4);
  endtask : rand_loop

  initial begin
    logic [6:0] s;
    rst_b = 1'b0;
    strap_cfg = 7'h0;
    pres_n = 2'h3;
    dev_req = 3'h0;
    needed = 3'h0;
    status = 3'h0;
    cyc = 0;
    fails = 0;
    total_checks = 0;
    for (int k = 0; k < 4; k++) begin
      s = 7'($random(seed));
      s[4] = k[0];
      if (k == 0) s = 7'h00;
      if (k == 1) s = 7'h7f;
      do_reset(s);
      if (!s[4]) req_scenario();
      rand_loop(s[4]);
      $display("Test %0d done, straps %h", k, s);
    end
    step(2);
    if (notes.size() != 0) fails++;
    complete_run();
  end
endmodule : port_config_strap_decode_tb

`default_nettype wire

// ---- verilog/pcsd_pkg.sv ----
`default_nettype none

package pcsd_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 3;                  // Ports 0..2
  localparam int SYNC_W    = 12;                 // Pins through the synchroniser

  // ----------------------------------------------------------------
  // Bit positions inside the synchronised pin vector
  // ----------------------------------------------------------------
  localparam int PIN_VC1_POS    = 0;             // Second channel strap
  localparam int PIN_POLDIS_POS = 1;             // Polarity detect disable strap
  localparam int PIN_PAYLD_POS  = 2;             // Large payload strap
  localparam int PIN_REFCLK_POS = 3;             // Common refclock strap
  localparam int PIN_SEL_POS    = 4;             // Substate or debug select
  localparam int PIN_SLOT_LSB   = 5;             // Slot connected, ports 1..2
  localparam int PIN_PRES_LSB   = 7;             // Presence, ports 1..2
  localparam int PIN_CREQ_LSB   = 9;             // Clock request lines, ports 0..2

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [NUM_PORTS-1:0] CREQ_OE_RST  = 3'h0;  // Pins released
  localparam logic [NUM_PORTS-1:0] CREQ_OUT_RST = 3'h0;  // Drive level low
  localparam logic [NUM_PORTS-1:0] CLK_EN_RST   = 3'h7;  // Clocks running
  localparam logic [NUM_PORTS-1:0] L1_RST       = 3'h0;  // Not in substate
  localparam logic [1:0]           PRES_RST     = 2'h3;  // Nobody present yet

  // ----------------------------------------------------------------
  // Max payload capability codes (device capability field)
  // ----------------------------------------------------------------
  localparam logic [2:0] MPS_256B = 3'h1;
  localparam logic [2:0] MPS_512B = 3'h2;

  // ----------------------------------------------------------------
  // Per-port reference clock state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    PCSD_CLK_ON  = 1'b0,                         // Refclock and PLL running
    PCSD_CLK_OFF = 1'b1                          // L1 substate, clocks stopped
  } pcsd_clk_state_type;

endpackage : pcsd_pkg

`default_nettype wire

// ---- verilog/pcsd_strap_decode.sv ----
`timescale 1ns/1ps
`default_nettype none

// Board strap decoder and shared clock-request / debug pin control
module pcsd_strap_decode
  import pcsd_pkg::*;
(
  // Clock and system reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Board straps and presence (asynchronous pins)
  input  wire logic                 second_channel_enable_strap,
  input  wire logic                 rx_polarity_detect_disable_strap,
  input  wire logic                 large_payload_strap,
  input  wire logic                 common_refclock_strap,
  input  wire logic                 substate_or_debug_select,
  input  wire logic [2:1]           slot_connected_strap,
  input  wire logic [2:1]           slot_presence_n,
  // Shared clock request (open-drain) / debug status (push-pull) pins
  input  wire logic [NUM_PORTS-1:0] clock_request_n_in,
  output logic      [NUM_PORTS-1:0] clock_request_n_out,
  output logic      [NUM_PORTS-1:0] clock_request_n_oe,
  // From the port logic (same clock)
  input  wire logic [NUM_PORTS-1:0] port_clock_needed,
  input  wire logic [NUM_PORTS-1:0] per_port_debug_status,
  // Decoded configuration to the port logic
  output logic                      vc1_capable,
  output logic                      vc0_extra_buffers,
  output logic                      rx_polarity_detect_enable,
  output logic      [2:0]           max_payload_code,
  output logic                      common_refclock_cfg,
  output logic      [2:1]           slot_connected,
  output logic      [2:1]           device_present,
  // Clock control per port
  output logic      [NUM_PORTS-1:0] refclk_enable,
  output logic      [NUM_PORTS-1:0] pll_enable,
  output logic      [NUM_PORTS-1:0] l1_substate_active
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0]    pin_sync;                // Two-flop copy of all pins
  logic [2:1]           pres_sync;               // Presence, synchronised
  logic [2:1]           slot_sync;               // Slot strap, synchronised
  logic [NUM_PORTS-1:0] creq_sync;               // Request line levels

  pcsd_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .pin_in   ({clock_request_n_in, slot_presence_n, slot_connected_strap,
                substate_or_debug_select, common_refclock_strap,
                large_payload_strap, rx_polarity_detect_disable_strap,
                second_channel_enable_strap}),
    .pin_sync (pin_sync)
  );

  assign pres_sync = pin_sync[PIN_PRES_LSB +: 2];
  assign slot_sync = pin_sync[PIN_SLOT_LSB +: 2];
  assign creq_sync = pin_sync[PIN_CREQ_LSB +: NUM_PORTS];

  // ----------------------------------------------------------------
  // Captured straps
  // ----------------------------------------------------------------
  logic       vc1_reg,    vc1_next;            // Second channel on
  logic       vc0x_reg,   vc0x_next;           // VC1 buffers lent to VC0
  logic       poldet_reg, poldet_next;         // Inversion detection on
  logic [2:0] mps_reg,    mps_next;            // Payload capability code
  logic       cclk_reg,   cclk_next;           // Common refclock reported
  logic [2:1] slot_reg,   slot_next;           // Slot or chip-to-chip
  logic       sel_reg,    sel_next;            // High selects debug status

  // Track the pins while reset is low, freeze at release.
  // These are sticky: reset never forces a constant here, it reloads.
  always_comb begin
    vc1_next    = vc1_reg;
    vc0x_next   = vc0x_reg;
    poldet_next = poldet_reg;
    mps_next    = mps_reg;
    cclk_next   = cclk_reg;
    slot_next   = slot_reg;
    sel_next    = sel_reg;
    if (!rst_b) begin
      vc1_next    = pin_sync[PIN_VC1_POS];
      vc0x_next   = ~pin_sync[PIN_VC1_POS];
      poldet_next = ~pin_sync[PIN_POLDIS_POS];
      mps_next    = pin_sync[PIN_PAYLD_POS] ? MPS_512B : MPS_256B;
      cclk_next   = pin_sync[PIN_REFCLK_POS];
      slot_next   = slot_sync;
      sel_next    = pin_sync[PIN_SEL_POS];
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    vc1_reg    <= vc1_next;
    vc0x_reg   <= vc0x_next;
    poldet_reg <= poldet_next;
    mps_reg    <= mps_next;
    cclk_reg   <= cclk_next;
    slot_reg   <= slot_next;
    sel_reg    <= sel_next;
  end

  assign vc1_capable               = vc1_reg;
  assign vc0_extra_buffers         = vc0x_reg;
  assign rx_polarity_detect_enable = poldet_reg;
  assign max_payload_code          = mps_reg;
  assign common_refclock_cfg       = cclk_reg;
  assign slot_connected            = slot_reg;

  // ----------------------------------------------------------------
  // Presence (dynamic, follows the pins)
  // ----------------------------------------------------------------
  logic [2:1] pres_reg, pres_next;               // High means device present

  // Low pin level means a card sits in the slot
  always_comb begin
    pres_next = rst_b ? ~pres_sync : ~PRES_RST;
  end

  // Registers only
  always_ff @(posedge clk) begin
    pres_reg <= pres_next;
  end

  assign device_present = pres_reg;

  // ----------------------------------------------------------------
  // Shared pins and clock control, one slice per port
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      pcsd_clk_state_type state_reg, state_next;  // Clock state of this port
      logic               oe_reg,    oe_next;     // Pin enable
      logic               out_reg,   out_next;    // Pin level when enabled
      logic               clk_on_reg, clk_on_next; // Refclock and PLL enable
      logic               l1_reg,     l1_next;     // Substate flag

      // Next state and pin drive
      always_comb begin
        state_next = state_reg;
        oe_next    = CREQ_OE_RST[gp];
        out_next   = CREQ_OUT_RST[gp];
        if (sel_reg) begin
          // Debug mode: push-pull status, clocks never stopped
          oe_next    = 1'b1;
          out_next   = per_port_debug_status[gp];
          state_next = PCSD_CLK_ON;
        end else begin
          // Open-drain: pull low only while the port wants its clock
          oe_next  = port_clock_needed[gp];
          out_next = 1'b0;
          unique case (state_reg)
            PCSD_CLK_ON:  if (creq_sync[gp])  state_next = PCSD_CLK_OFF;
            PCSD_CLK_OFF: if (!creq_sync[gp]) state_next = PCSD_CLK_ON;
          endcase
        end
        if (!rst_b) begin
          // Pins released during reset, clocks left running
          state_next = PCSD_CLK_ON;
          oe_next    = CREQ_OE_RST[gp];
          out_next   = CREQ_OUT_RST[gp];
        end
        // Enables decoded from the next state so they move in the
        // same edge as the state itself
        clk_on_next = (state_next == PCSD_CLK_ON);
        l1_next     = (state_next == PCSD_CLK_OFF);
      end

      // Registers only
      always_ff @(posedge clk) begin
        state_reg  <= state_next;
        oe_reg     <= oe_next;
        out_reg    <= out_next;
        clk_on_reg <= clk_on_next;
        l1_reg     <= l1_next;
      end

      assign clock_request_n_oe[gp]  = oe_reg;
      assign clock_request_n_out[gp] = out_reg;
      assign refclk_enable[gp]       = clk_on_reg;
      assign pll_enable[gp]          = clk_on_reg;
      assign l1_substate_active[gp]  = l1_reg;

      // --------------------------------------------------------------
      // Checks for this port
      // --------------------------------------------------------------
      AST_CREQ_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && !sel_reg && port_clock_needed[gp]
          |=> clock_request_n_oe[gp] && !clock_request_n_out[gp])
        else $error("clock request not pulled low when needed");
      AST_DEBUG_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && sel_reg
          |=> clock_request_n_oe[gp] && clock_request_n_out[gp] == $past(per_port_debug_status[gp]))
        else $error("debug status not driven on shared pin");
      AST_L1_ENTER: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && !sel_reg && creq_sync[gp]
          |=> !pll_enable[gp] && !refclk_enable[gp] && l1_substate_active[gp])
        else $error("clocks not stopped on released request");
      AST_L1_EXIT: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && !creq_sync[gp]
          |=> pll_enable[gp] && refclk_enable[gp] && !l1_substate_active[gp])
        else $error("clocks not restarted on asserted request");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks on the captured straps and on presence
  // ----------------------------------------------------------------
  AST_VC1_CAPTURE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> vc1_capable == $past(pin_sync[PIN_VC1_POS]))
    else $error("second channel strap not captured at release");
  AST_VC0_SHARE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> vc0_extra_buffers == !$past(pin_sync[PIN_VC1_POS]) && vc0_extra_buffers != vc1_capable)
    else $error("VC0 sharing disagrees with VC1 enable");
  AST_POLDET: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> rx_polarity_detect_enable == !$past(pin_sync[PIN_POLDIS_POS]))
    else $error("polarity detect enable wrong after release");
  AST_PAYLOAD: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> max_payload_code == ($past(pin_sync[PIN_PAYLD_POS]) ? MPS_512B : MPS_256B))
    else $error("payload capability code wrong");
  AST_PRESENT: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> device_present == ~$past(pres_sync))
    else $error("presence not decoded active low");
  AST_REFCLK_CFG: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> common_refclock_cfg == $past(pin_sync[PIN_REFCLK_POS]))
    else $error("common refclock report wrong");
  AST_SLOT: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> slot_connected == $past(slot_sync))
    else $error("slot connected strap not captured");
  AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> $stable(vc1_capable) && $stable(max_payload_code) && $stable(sel_reg)
      && $stable(slot_connected) && $stable(rx_polarity_detect_enable))
    else $error("captured straps changed outside reset");

endmodule : pcsd_strap_decode

`default_nettype wire

// ---- verilog/pcsd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a group of slow pins
module pcsd_sync
  import pcsd_pkg::*;
#(
  parameter int W = SYNC_W
) (
  // Clock
  input  wire logic         clk,
  // Pins and synchronised copy
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_reg;                        // First stage, read by stage two only
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;                        // Second stage, safe to use
  logic [W-1:0] sync_next;

  // Next values: no reset here on purpose, the stages keep following
  // the pins while reset is low so the strap capture sees real levels.
  // Presence and clock logic apply their own reset values downstream; the straps reload.
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
  end

  // Registers only
  always_ff @(posedge clk) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign pin_sync = sync_reg;

endmodule : pcsd_sync

`default_nettype wire
